// ---- rtl/pmsdt_core.v ----
// Power sequencing delay timer: rail on/off sequencing, sleep state machine,
// reset release timer, GPIO delays, thermal supervision and APB registers.
// Assumes all inputs are synchronous to clk and die_temp_c is in whole degrees C.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "pmsdt_defs.vh"

module pmsdt_core #(
	parameter NUM_RAILS   = 5,
	parameter NUM_GPIO    = 4,
	parameter TICK_CYCLES = `PMSDT_TICK_CYCLES
) (
	// Clock and reset.
	input  wire                 clk,
	input  wire                 nrst,
	// APB slave.
	input  wire                 psel,
	input  wire                 penable,
	input  wire                 pwrite,
	input  wire [7:0]           paddr,
	input  wire [31:0]          pwdata,
	output reg  [31:0]          prdata,
	output reg                  pready,
	output reg                  pslverr,
	// Supply, pin and sensor inputs.
	input  wire                 analog_supply_ok,
	input  wire                 low_quiescent_select_n,
	input  wire                 power_enable_pin,
	input  wire [7:0]           die_temp_c,
	input  wire [NUM_RAILS-1:0] rail_good,
	input  wire [NUM_GPIO-1:0]  gpio_in,
	// Outputs.
	output reg  [NUM_RAILS-1:0] rail_en,
	output reg  [NUM_GPIO-1:0]  gpio_out,
	output reg                  reset_out_n,
	output reg                  thermal_shutdown,
	output reg                  irq
);

	localparam ST_UVLO  = 3'd0;
	localparam ST_LAT   = 3'd1;
	localparam ST_ON    = 3'd2;
	localparam ST_SLEEP = 3'd3;
	localparam ST_DEEP  = 3'd4;
	localparam ST_THERM = 3'd5;

	localparam [7:0] WARN_SET_C = `PMSDT_TRIP_C - `PMSDT_TRIP_HYST_C;
	localparam [7:0] WARN_CLR_C = `PMSDT_TRIP_C - `PMSDT_TRIP_HYST_C - `PMSDT_WARN_HYST_C;
	localparam [7:0] TRIP_SET_C = `PMSDT_TRIP_C;
	localparam [7:0] TRIP_CLR_C = `PMSDT_TRIP_C - `PMSDT_TRIP_HYST_C;

	localparam [10:0] LAT_START    = `PMSDT_START_US / `PMSDT_TICK_US;
	localparam [10:0] LAT_START_LQ = `PMSDT_START_LQ_US / `PMSDT_TICK_US;
	localparam [10:0] LAT_PIN      = `PMSDT_PIN_US / `PMSDT_TICK_US;
	localparam [10:0] LAT_SLEEP    = `PMSDT_SLEEP_US / `PMSDT_TICK_US;
	localparam [10:0] LAT_OFF      = `PMSDT_OFF_US / `PMSDT_TICK_US;

	function [15:0] seq_ticks;
		input [2:0] code;
		begin
			case (code)
			3'd1:    seq_ticks = `PMSDT_SEQ_US_1 / `PMSDT_TICK_US;
			3'd2:    seq_ticks = `PMSDT_SEQ_US_2 / `PMSDT_TICK_US;
			3'd3:    seq_ticks = `PMSDT_SEQ_US_3 / `PMSDT_TICK_US;
			3'd4:    seq_ticks = `PMSDT_SEQ_US_4 / `PMSDT_TICK_US;
			3'd5:    seq_ticks = `PMSDT_SEQ_US_5 / `PMSDT_TICK_US;
			3'd6:    seq_ticks = `PMSDT_SEQ_US_6 / `PMSDT_TICK_US;
			3'd7:    seq_ticks = `PMSDT_SEQ_US_7 / `PMSDT_TICK_US;
			default: seq_ticks = 16'h0000;
			endcase
		end
	endfunction

	function [16:0] rst_ticks;
		input [2:0] code;
		begin
			case (code)
			3'd0:    rst_ticks = `PMSDT_RST_US_0 / `PMSDT_TICK_US;
			3'd1:    rst_ticks = `PMSDT_RST_US_1 / `PMSDT_TICK_US;
			3'd2:    rst_ticks = `PMSDT_RST_US_2 / `PMSDT_TICK_US;
			3'd3:    rst_ticks = `PMSDT_RST_US_3 / `PMSDT_TICK_US;
			3'd4:    rst_ticks = `PMSDT_RST_US_4 / `PMSDT_TICK_US;
			3'd5:    rst_ticks = `PMSDT_RST_US_5 / `PMSDT_TICK_US;
			3'd6:    rst_ticks = `PMSDT_RST_US_6 / `PMSDT_TICK_US;
			default: rst_ticks = `PMSDT_RST_US_7 / `PMSDT_TICK_US;
			endcase
		end
	endfunction

	function [13:0] gpio_ticks;
		input [1:0] code;
		begin
			case (code)
			2'd1:    gpio_ticks = `PMSDT_GPIO_US_1 / `PMSDT_TICK_US;
			2'd2:    gpio_ticks = `PMSDT_GPIO_US_2 / `PMSDT_TICK_US;
			2'd3:    gpio_ticks = `PMSDT_GPIO_US_3 / `PMSDT_TICK_US;
			default: gpio_ticks = 14'h0000;
			endcase
		end
	endfunction

	reg  [31:0] ctrl;
	reg  [31:0] rail_on_delay_sel;
	reg  [31:0] rail_off_delay_sel;
	reg  [31:0] rst_cfg;
	reg  [31:0] gpio_delay_sel;
	reg  [2:0]  irq_stat;
	reg  [2:0]  irq_en;
	reg         off_cmd;
	reg  [15:0] tick_cnt;
	reg         tick;
	reg  [2:0]  state;
	reg  [2:0]  lat_dest;
	reg  [10:0] lat_cnt;
	reg  [10:0] lat_len;
	reg         rails_want;
	reg         pin_q;
	reg         warn_level;
	reg  [16:0] rst_cnt;
	reg  [2:0]  next_irq_stat;
	reg  [31:0] next_rdata;
	reg         next_err;

	wire        apb_acc = psel & penable & ~pready;
	wire        apb_wr  = psel & penable & pready & pwrite;
	wire        pin_rise = power_enable_pin & ~pin_q;
	wire        pin_fall = ~power_enable_pin & pin_q;
	wire        sleep_req = ctrl[`PMSDT_CTRL_SLEEP];
	wire [NUM_RAILS-1:0] rst_mask = rst_cfg[`PMSDT_RST_MASK_LSB +: NUM_RAILS];
	wire        rails_ok = rails_want & (&(rail_good | ~rst_mask));
	wire [16:0] rst_len = rst_ticks(rst_cfg[2:0]);

	// One timebase tick drives every delay counter.
	always @(posedge clk) begin
		if (!nrst) begin
			tick_cnt <= 16'h0000;
			tick     <= 1'b0;
		end else if (tick_cnt == TICK_CYCLES[15:0] - 16'h0001) begin
			tick_cnt <= 16'h0000;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 16'h0001;
			tick     <= 1'b0;
		end
	end

	// Thermal supervision with separate hysteresis for trip and warning.
	always @(posedge clk) begin
		if (!nrst) begin
			thermal_shutdown <= 1'b0;
			warn_level       <= 1'b0;
		end else begin
			if (die_temp_c >= TRIP_SET_C)
				thermal_shutdown <= 1'b1;
			else if (die_temp_c <= TRIP_CLR_C)
				thermal_shutdown <= 1'b0;
			if (die_temp_c >= WARN_SET_C)
				warn_level <= 1'b1;
			else if (die_temp_c <= WARN_CLR_C)
				warn_level <= 1'b0;
		end
	end

	// Power state machine. Every transition except entry to ST_THERM or ST_UVLO passes
	// through ST_LAT, whose latency is counted before the rail sequencers see the new target.
	always @(posedge clk) begin
		if (!nrst) begin
			state      <= ST_UVLO;
			lat_dest   <= ST_UVLO;
			lat_cnt    <= 11'h000;
			lat_len    <= 11'h000;
			rails_want <= 1'b0;
			pin_q      <= 1'b0;
		end else begin
			pin_q <= power_enable_pin;
			if (thermal_shutdown) begin
				state      <= ST_THERM;
				rails_want <= 1'b0;
			end else if (!analog_supply_ok) begin
				state      <= ST_UVLO;
				rails_want <= 1'b0;
			end else begin
				case (state)
				ST_UVLO, ST_THERM: begin
					state    <= ST_LAT;
					lat_dest <= ST_ON;
					lat_cnt  <= 11'h000;
					lat_len  <= low_quiescent_select_n ? LAT_START : LAT_START_LQ;
				end
				ST_LAT: begin
					if (tick) begin
						if (lat_cnt >= lat_len - 11'h001) begin
							state      <= lat_dest;
							rails_want <= (lat_dest == ST_ON);
						end else begin
							lat_cnt <= lat_cnt + 11'h001;
						end
					end
				end
				ST_ON: begin
					lat_cnt <= 11'h000;
					if (pin_fall) begin
						state    <= ST_LAT;
						lat_dest <= ST_DEEP;
						lat_len  <= LAT_PIN;
					end else if (off_cmd) begin
						state    <= ST_LAT;
						lat_dest <= ST_DEEP;
						lat_len  <= LAT_OFF;
					end else if (sleep_req) begin
						state    <= ST_LAT;
						lat_dest <= ST_SLEEP;
						lat_len  <= LAT_SLEEP;
					end
				end
				ST_SLEEP: begin
					lat_cnt <= 11'h000;
					if (!sleep_req) begin
						state    <= ST_LAT;
						lat_dest <= ST_ON;
						lat_len  <= LAT_SLEEP;
					end
				end
				ST_DEEP: begin
					lat_cnt <= 11'h000;
					if (pin_rise) begin
						state    <= ST_LAT;
						lat_dest <= ST_ON;
						lat_len  <= LAT_PIN;
					end
				end
				default: state <= ST_UVLO;
				endcase
			end
		end
	end

	// Each rail follows the target after its own on or off delay. A thermal
	// trip bypasses the off delay, since the die must not stay loaded.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_RAILS; gi = gi + 1) begin : g_rail
			reg  [15:0] rc;
			wire [15:0] dly = rails_want ? seq_ticks(rail_on_delay_sel[3*gi +: 3])
			                             : seq_ticks(rail_off_delay_sel[3*gi +: 3]);
			always @(posedge clk) begin
				if (!nrst) begin
					rc         <= 16'h0000;
					rail_en[gi] <= 1'b0;
				end else if (rail_en[gi] == rails_want) begin
					rc <= 16'h0000;
				end else if (dly == 16'h0000 || thermal_shutdown) begin
					rail_en[gi] <= rails_want;
					rc          <= 16'h0000;
				end else if (tick) begin
					if (rc >= dly - 16'h0001) begin
						rail_en[gi] <= rails_want;
						rc          <= 16'h0000;
					end else begin
						rc <= rc + 16'h0001;
					end
				end
			end
		end
		// A GPIO change must stay stable for the whole delay to pass.
		for (gi = 0; gi < NUM_GPIO; gi = gi + 1) begin : g_gpio
			reg  [13:0] gc;
			wire [13:0] gd = gpio_ticks(gpio_delay_sel[2*gi +: 2]);
			always @(posedge clk) begin
				if (!nrst) begin
					gc           <= 14'h0000;
					gpio_out[gi] <= 1'b0;
				end else if (gpio_in[gi] == gpio_out[gi]) begin
					gc <= 14'h0000;
				end else if (gd == 14'h0000) begin
					gpio_out[gi] <= gpio_in[gi];
				end else if (tick) begin
					if (gc >= gd - 14'h0001) begin
						gpio_out[gi] <= gpio_in[gi];
						gc           <= 14'h0000;
					end else begin
						gc <= gc + 14'h0001;
					end
				end
			end
		end
	endgenerate

	// Reset release timer restarts whenever any monitored rail drops.
	always @(posedge clk) begin
		if (!nrst) begin
			reset_out_n <= 1'b0;
			rst_cnt     <= 17'h00000;
		end else if (!rails_ok) begin
			reset_out_n <= 1'b0;
			rst_cnt     <= 17'h00000;
		end else if (!reset_out_n && tick) begin
			if (rst_cnt >= rst_len - 17'h00001)
				reset_out_n <= 1'b1;
			else
				rst_cnt <= rst_cnt + 17'h00001;
		end
	end

	// Sticky events: a set in the same cycle as a clear wins.
	always @* begin
		next_irq_stat = irq_stat;
		if (apb_wr && paddr == `PMSDT_ADDR_IRQ_CLR)
			next_irq_stat = irq_stat & ~pwdata[2:0];
		if (warn_level == 1'b0 && die_temp_c >= WARN_SET_C)
			next_irq_stat[`PMSDT_IRQ_WARN] = 1'b1;
		if (!thermal_shutdown && die_temp_c >= TRIP_SET_C)
			next_irq_stat[`PMSDT_IRQ_TRIP] = 1'b1;
		if (!reset_out_n && rails_ok && tick && rst_cnt >= rst_len - 17'h00001)
			next_irq_stat[`PMSDT_IRQ_RSTREL] = 1'b1;
	end

	always @* begin
		next_err   = 1'b0;
		next_rdata = 32'h0000_0000;
		case (paddr)
		`PMSDT_ADDR_CTRL:     next_rdata = {31'h0000_0000, sleep_req};
		`PMSDT_ADDR_ON_DLY:   next_rdata = rail_on_delay_sel;
		`PMSDT_ADDR_OFF_DLY:  next_rdata = rail_off_delay_sel;
		`PMSDT_ADDR_RST_CFG:  next_rdata = rst_cfg;
		`PMSDT_ADDR_GPIO_DLY: next_rdata = gpio_delay_sel;
		`PMSDT_ADDR_STATUS:   next_rdata = {20'h00000, rail_en, warn_level,
		                                    thermal_shutdown, reset_out_n, rails_want, state};
		`PMSDT_ADDR_IRQ_STAT: next_rdata = {29'h0000_0000, irq_stat};
		`PMSDT_ADDR_IRQ_CLR:  next_rdata = 32'h0000_0000;
		`PMSDT_ADDR_IRQ_EN:   next_rdata = {29'h0000_0000, irq_en};
		default:              next_err   = 1'b1;
		endcase
	end

	// APB slave: pready rises one cycle into the access phase.
	always @(posedge clk) begin
		if (!nrst) begin
			pready             <= 1'b0;
			pslverr            <= 1'b0;
			prdata             <= 32'h0000_0000;
			ctrl               <= 32'h0000_0000;
			rail_on_delay_sel  <= `PMSDT_RST_ON_DLY;
			rail_off_delay_sel <= `PMSDT_RST_OFF_DLY;
			rst_cfg            <= `PMSDT_RST_RST_CFG;
			gpio_delay_sel     <= `PMSDT_RST_GPIO_DLY;
			irq_stat           <= 3'h0;
			irq_en             <= 3'h0;
			off_cmd            <= 1'b0;
			irq                <= 1'b0;
		end else begin
			pready   <= apb_acc;
			pslverr  <= apb_acc & next_err;
			prdata   <= (apb_acc && !pwrite) ? next_rdata : 32'h0000_0000;
			irq_stat <= next_irq_stat;
			irq      <= |(next_irq_stat & irq_en);
			off_cmd  <= apb_wr && paddr == `PMSDT_ADDR_CTRL && pwdata[`PMSDT_CTRL_OFF];
			if (apb_wr) begin
				case (paddr)
				`PMSDT_ADDR_CTRL:     ctrl <= {31'h0000_0000, pwdata[`PMSDT_CTRL_SLEEP]};
				`PMSDT_ADDR_ON_DLY:   rail_on_delay_sel <= {17'h00000, pwdata[14:0]};
				`PMSDT_ADDR_OFF_DLY:  rail_off_delay_sel <= {17'h00000, pwdata[14:0]};
				`PMSDT_ADDR_RST_CFG:  rst_cfg <= {19'h00000, pwdata[12:8], 5'h00, pwdata[2:0]};
				`PMSDT_ADDR_GPIO_DLY: gpio_delay_sel <= {24'h000000, pwdata[7:0]};
				`PMSDT_ADDR_IRQ_EN:   irq_en <= pwdata[2:0];
				default:              ctrl <= ctrl;
				endcase
			end
		end
	end

endmodule

// ---- rtl/pmsdt_defs.vh ----
// Constants for the power sequencing delay timer: register map, field layout,
// reset values, delay tables and latency figures.
// Assumes a 200 MHz clock and a 1 us internal timebase tick.
`ifndef PMSDT_DEFS_VH
`define PMSDT_DEFS_VH

// Timebase.
`define PMSDT_CLK_MHZ        200
`define PMSDT_TICK_US        1
`define PMSDT_TICK_CYCLES    (`PMSDT_TICK_US * `PMSDT_CLK_MHZ)

// APB register byte addresses.
`define PMSDT_ADDR_CTRL      8'h00
`define PMSDT_ADDR_ON_DLY    8'h04
`define PMSDT_ADDR_OFF_DLY   8'h08
`define PMSDT_ADDR_RST_CFG   8'h0C
`define PMSDT_ADDR_GPIO_DLY  8'h10
`define PMSDT_ADDR_STATUS    8'h14
`define PMSDT_ADDR_IRQ_STAT  8'h18
`define PMSDT_ADDR_IRQ_CLR   8'h1C
`define PMSDT_ADDR_IRQ_EN    8'h20

// Field positions.
`define PMSDT_CTRL_SLEEP     0
`define PMSDT_CTRL_OFF       1
`define PMSDT_RST_MASK_LSB   8
`define PMSDT_IRQ_WARN       0
`define PMSDT_IRQ_TRIP       1
`define PMSDT_IRQ_RSTREL     2

// Reset values.
`define PMSDT_RST_ON_DLY     32'h0000_0000
`define PMSDT_RST_OFF_DLY    32'h0000_0000
`define PMSDT_RST_RST_CFG    32'h0000_1F00
`define PMSDT_RST_GPIO_DLY   32'h0000_0000

// Sequencing delays, in us (0.5 ms .. 32 ms).
`define PMSDT_SEQ_US_1       500
`define PMSDT_SEQ_US_2       1000
`define PMSDT_SEQ_US_3       2000
`define PMSDT_SEQ_US_4       4000
`define PMSDT_SEQ_US_5       8000
`define PMSDT_SEQ_US_6       16000
`define PMSDT_SEQ_US_7       32000
// Reset release delays, in us (0.5 ms .. 100 ms).
`define PMSDT_RST_US_0       500
`define PMSDT_RST_US_1       1000
`define PMSDT_RST_US_2       2500
`define PMSDT_RST_US_3       5000
`define PMSDT_RST_US_4       10000
`define PMSDT_RST_US_5       20000
`define PMSDT_RST_US_6       50000
`define PMSDT_RST_US_7       100000
// GPIO delays, in us (1, 5, 10 ms).
`define PMSDT_GPIO_US_1      1000
`define PMSDT_GPIO_US_2      5000
`define PMSDT_GPIO_US_3      10000

// Transition latencies, in us.
`define PMSDT_START_US       620
`define PMSDT_START_LQ_US    920
`define PMSDT_PIN_US         224
`define PMSDT_SLEEP_US       84
`define PMSDT_OFF_US         180

// Thermal levels, in degrees C.
`define PMSDT_TRIP_C         155
`define PMSDT_TRIP_HYST_C    30
`define PMSDT_WARN_HYST_C    20

`endif

// ---- verif/pmsdt_core_sva.sv ----
// Checker for the sequencing delay timer, bound to the core's ports.
// Assumes the reset rail mask is left at its reset value, covering every rail.
`timescale 1ns/1ps

module pmsdt_core_sva #(
	parameter NUM_RAILS = 5
) (
	input wire logic                 clk,
	input wire logic                 nrst,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire logic                 analog_supply_ok,
	input wire logic [7:0]           die_temp_c,
	input wire logic [NUM_RAILS-1:0] rail_good,
	input wire logic [NUM_RAILS-1:0] rail_en,
	input wire logic                 reset_out_n,
	input wire logic                 thermal_shutdown
);
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("pready held longer than one cycle");

	property p_ready_access;
		pready |-> $past(psel) && $past(penable);
	endproperty
	a_ready_access: assert property (p_ready_access)
		else $error("pready without a prior access cycle");

	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready)
		else $error("pslverr outside the answer cycle");

	property p_rdata_idle;
		!pready |-> prdata == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("prdata not zero outside the answer cycle");

	property p_trip;
		die_temp_c >= 8'd155 |-> ##[1:2] thermal_shutdown;
	endproperty
	a_trip: assert property (p_trip)
		else $error("no shutdown at trip temperature");

	property p_trip_off;
		thermal_shutdown |-> ##[1:3] rail_en == {NUM_RAILS{1'b0}};
	endproperty
	a_trip_off: assert property (p_trip_off)
		else $error("rails still on during shutdown");

	property p_rst_drop;
		!(&rail_good) |=> !reset_out_n;
	endproperty
	a_rst_drop: assert property (p_rst_drop)
		else $error("reset released while a rail is not good");

	property p_rst_rise;
		$rose(reset_out_n) |-> (&rail_good) && $past(&rail_good);
	endproperty
	a_rst_rise: assert property (p_rst_rise)
		else $error("reset rose without rails good");

	property p_start_hold;
		$rose(analog_supply_ok) |-> (rail_en == {NUM_RAILS{1'b0}}) [*8];
	endproperty
	a_start_hold: assert property (p_start_hold)
		else $error("rail enabled without startup latency");
endmodule

bind pmsdt_core pmsdt_core_sva #(.NUM_RAILS(NUM_RAILS)) pmsdt_core_sva_i (
	.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .analog_supply_ok(analog_supply_ok),
	.die_temp_c(die_temp_c), .rail_good(rail_good), .rail_en(rail_en),
	.reset_out_n(reset_out_n), .thermal_shutdown(thermal_shutdown));

// ---- verif/pmsdt_rail_model.sv ----
// Model of the regulated rails behind the core.
// A rail reports good a chosen number of cycles after its enable, and drops
// good at once when disabled, so a slow ramp can be set from the bench.
`timescale 1ns/1ps

module pmsdt_rail_model #(
	parameter NUM_RAILS = 5
) (
	input  wire logic                 clk,
	input  wire logic [7:0]           ramp_cycles,
	input  wire logic [NUM_RAILS-1:0] rail_en,
	output logic      [NUM_RAILS-1:0] rail_good
);
	logic [7:0] cnt [NUM_RAILS];

	always @(posedge clk) begin
		for (int i = 0; i < NUM_RAILS; i++) begin
			if (!rail_en[i]) begin
				cnt[i] <= 8'h00;
				rail_good[i] <= 1'b0;
			end else if (cnt[i] < ramp_cycles) begin
				cnt[i] <= cnt[i] + 8'h01;
			end else begin
				rail_good[i] <= 1'b1;
			end
		end
	end
endmodule

// ---- verif/pmsdt_core_test.sv ----
// Self-checking bench for the sequencing delay timer over APB.
// Assumes a 2-cycle tick so every delay runs 100 times faster.
`timescale 1ns/1ps
`include "pmsdt_defs.vh"

module pmsdt_core_test;
	localparam T = 2;
	logic        clk, nrst, psel, penable, pwrite, sup_ok, lq_n, pen;
	logic [7:0]  paddr, temp, ramp;
	logic [31:0] pwdata, r;
	logic [3:0]  gpio_in;
	wire  [31:0] prdata;
	wire         pready, pslverr, reset_out_n, tsd, irq;
	wire  [4:0]  rail_en, rail_good;
	wire  [3:0]  gpio_out;
	logic [32:0] exp_q[$];
	int          fails, cmp_count, seed;

	pmsdt_core #(.TICK_CYCLES(T)) pmsdt_core_i (.clk(clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .analog_supply_ok(sup_ok),
		.low_quiescent_select_n(lq_n), .power_enable_pin(pen), .die_temp_c(temp),
		.rail_good(rail_good), .gpio_in(gpio_in), .rail_en(rail_en),
		.gpio_out(gpio_out), .reset_out_n(reset_out_n), .thermal_shutdown(tsd),
		.irq(irq));
	pmsdt_rail_model pmsdt_rail_model_i (.clk(clk), .ramp_cycles(ramp),
		.rail_en(rail_en), .rail_good(rail_good));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic finish_test();
		$display("Compares %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [32:0] e, input logic [32:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask

	// Read results are noted here and compared by the watcher below.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			input logic [32:0] e);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr)
			exp_q.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			chk("pready", 33'h1, 33'h0);
			finish_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		apb(1'b0, a, 32'h0, e);
	endtask

	always @(posedge clk) begin
		if (pready === 1'b1 && pwrite === 1'b0) begin
			if (exp_q.size() == 0)
				chk("unexpected read", 33'h0, 33'h1);
			else
				chk("apb read", exp_q.pop_front(), {pslverr, prdata});
		end
	end

	function automatic logic sig(input int s);
		case (s)
			0: return rail_en[0];
			1: return rail_en[1];
			2: return reset_out_n;
			3: return irq;
			4: return tsd;
			default: return gpio_out[1];
		endcase
	endfunction

	// Waits for an output level and checks that it came after us ticks, from one tick and 2 cycles early to one tick and 6 cycles late.
	task automatic wait_us(input string what, input int s, input logic v, input int us);
		int n;
		n = 0;
		while (sig(s) !== v && n <= (us + 1) * T + 6) begin
			@(posedge clk);
			n++;
		end
		chk(what, 33'h1, {32'h0, n >= (us - 1) * T - 2 && n <= (us + 1) * T + 6});
		if (n > (us + 1) * T + 6)
			finish_test();
	endtask

	initial begin
		seed = 78;
		{nrst, psel, penable, pwrite, sup_ok, paddr, pwdata, gpio_in} = '0;
		lq_n = 1'b1;
		pen = 1'b1;
		temp = 8'd40;
		ramp = 8'd3;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(`PMSDT_ADDR_RST_CFG, {1'b0, `PMSDT_RST_RST_CFG});
		rd(`PMSDT_ADDR_ON_DLY, {1'b0, `PMSDT_RST_ON_DLY});
		rd(`PMSDT_ADDR_GPIO_DLY, {1'b0, `PMSDT_RST_GPIO_DLY});
		rd(8'h24, 33'h1_0000_0000);
		rd(`PMSDT_ADDR_IRQ_CLR, 33'h0);
		wr(`PMSDT_ADDR_ON_DLY, 32'h0000_0008);
		wr(`PMSDT_ADDR_OFF_DLY, 32'h0000_0008);
		wr(`PMSDT_ADDR_IRQ_EN, 32'h0000_0005);
		sup_ok <= 1'b1;
		wait_us("start", 0, 1'b1, `PMSDT_START_US);
		wait_us("on delay", 1, 1'b1, `PMSDT_SEQ_US_1);
		wait_us("reset release", 2, 1'b1, `PMSDT_RST_US_0);
		wait_us("irq up", 3, 1'b1, 0);
		rd(`PMSDT_ADDR_IRQ_STAT, 33'h4);
		rd(`PMSDT_ADDR_STATUS, 33'h0_0000_0F9A);
		wr(`PMSDT_ADDR_IRQ_CLR, 32'h0000_0004);
		wait_us("irq down", 3, 1'b0, 0);
		$display("startup done");
		ramp <= 8'd40;
		wr(`PMSDT_ADDR_CTRL, 32'h0000_0002);
		wait_us("off cmd", 0, 1'b0, `PMSDT_OFF_US);
		wait_us("off delay", 1, 1'b0, `PMSDT_SEQ_US_1);
		pen <= 1'b0;
		repeat (3) @(posedge clk);
		pen <= 1'b1;
		wait_us("pin wake", 0, 1'b1, `PMSDT_PIN_US);
		wait_us("on delay 2", 1, 1'b1, `PMSDT_SEQ_US_1);
		pen <= 1'b0;
		wait_us("pin sleep", 0, 1'b0, `PMSDT_PIN_US);
		wait_us("off delay 2", 1, 1'b0, `PMSDT_SEQ_US_1);
		pen <= 1'b1;
		wait_us("pin wake 2", 0, 1'b1, `PMSDT_PIN_US);
		wait_us("on delay 3", 1, 1'b1, `PMSDT_SEQ_US_1);
		wr(`PMSDT_ADDR_CTRL, 32'h0000_0001);
		wait_us("sleep", 0, 1'b0, `PMSDT_SLEEP_US);
		wait_us("off delay 3", 1, 1'b0, `PMSDT_SEQ_US_1);
		wr(`PMSDT_ADDR_CTRL, 32'h0000_0000);
		wait_us("sleep exit", 0, 1'b1, `PMSDT_SLEEP_US);
		$display("sequencing done");
		temp <= 8'd125;
		wait_us("warn irq", 3, 1'b1, 0);
		rd(`PMSDT_ADDR_IRQ_STAT, 33'h1);
		temp <= 8'd155;
		wait_us("trip", 4, 1'b1, 0);
		temp <= 8'd126;
		repeat (10) @(posedge clk);
		chk("trip hold", 33'h1, {32'h0, tsd});
		temp <= 8'd105;
		lq_n <= 1'b0;
		wait_us("trip clear", 4, 1'b0, 0);
		wait_us("restart", 0, 1'b1, `PMSDT_START_LQ_US);
		wr(`PMSDT_ADDR_IRQ_CLR, 32'h0000_0003);
		wait_us("irq clear", 3, 1'b0, 0);
		$display("thermal done");
		wr(`PMSDT_ADDR_GPIO_DLY, 32'h0000_0004);
		repeat (4) begin
			r = $random(seed);
			gpio_in[0] <= r[0];
			repeat (3) @(posedge clk);
			chk("gpio0", {32'h0, r[0]}, {32'h0, gpio_out[0]});
		end
		gpio_in[1] <= 1'b1;
		wait_us("gpio1", 5, 1'b1, `PMSDT_GPIO_US_1);
		$display("gpio done");
		finish_test();
	end
endmodule
